// *** bench/boot_clock_sequencer_monitor.sv ***
// boot_clock_sequencer_monitor.sv: port checker for the boot sequencer
// assumes it is bound to every boot_clock_sequencer instance
`timescale 1ns/1ps
`default_nettype none
module boot_seq_monitor
  import boot_seq_pkg::*;
#(
  parameter logic [15:0] BOOT_SIGNATURE = 16'h0A_5A,
  parameter int unsigned MS_CYCLES      = 200000
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        rtc_osc_en_in,
  input wire logic        ref_from_ext_out,
  input wire logic        rtc_access_ok_out,
  input wire pll_cfg_t    pll_cfg_out,
  input wire logic        clock_output_pin_slow_slew_out,
  input wire logic        clock_output_pin_en_out,
  input wire logic        bandgap_trim_out,
  input wire logic [15:0] idle_config_out,
  input wire logic [15:0] periph_gate_ctrl_a_out,
  input wire logic [15:0] periph_gate_ctrl_b_out,
  input wire logic        usb_osc_disable_out,
  input wire logic        memory_map_mode_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic        probe_valid_out,
  input wire probe_req_t  probe_req_out,
  input wire logic        probe_done_in,
  input wire logic [15:0] probe_data_in,
  input wire logic        load_valid_out,
  input wire load_req_t   load_req_out,
  input wire logic        load_done_in,
  input wire logic        cfg_present_in,
  input wire logic [23:0] entry_addr_in,
  input wire logic        jump_out,
  input wire logic [23:0] entry_out
);
  // ------------
  // helper logic
  // ------------
  wire logic [31:0] gates = {periph_gate_ctrl_b_out, periph_gate_ctrl_a_out};
  wire logic        hit   = probe_done_in && probe_data_in == BOOT_SIGNATURE;
  logic [31:0] settle;
  logic [23:0] hit_entry;
  logic        hit_cfg;
  // 32 bits: the full settle count fits
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      settle    <= '0;
      hit_entry <= '0;
      hit_cfg   <= 1'b0;
    end else begin
      settle <= (load_done_in && load_req_out.kind == LOAD_COPY) ? '0
                : settle + 32'h0000_0001;
      if (hit) begin
        hit_entry <= entry_addr_in;
        hit_cfg   <= cfg_present_in;
      end
    end
  end
  // ------------
  // assertions
  // ------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  reset_state_a: assert property ($rose(rst_n_in) |-> gates == '0
    && fetch_addr_out == 24'hFF_FF00 && !memory_map_mode_out
    && pll_cfg_out.bypass && usb_osc_disable_out) else $error("reset state");
  prep_done_a: assert property (probe_valid_out |-> clock_output_pin_slow_slew_out
    && !clock_output_pin_en_out && bandgap_trim_out
    && idle_config_out == 16'hFF_FE) else $error("prep steps missing");
  one_gate_a: assert property (probe_valid_out |-> $onehot(gates))
    else $error("probe gate not one-hot");
  pll_rtc_a: assert property (probe_valid_out && !ref_from_ext_out
    && probe_req_out.src != SRC_USB |-> pll_cfg_out ==
    {1'b1, 1'b0, 12'h2_ED, 2'h0, 1'b0, 1'b1, 1'b1, 7'h00})
    else $error("pll not at 375x");
  pll_bypass_a: assert property (probe_valid_out && ref_from_ext_out
    && probe_req_out.src != SRC_USB |-> pll_cfg_out.bypass)
    else $error("pll not bypassed");
  usb_retune_a: assert property (probe_valid_out
    && probe_req_out.src == SRC_USB |-> !pll_cfg_out.bypass
    && !usb_osc_disable_out && pll_cfg_out.mult ==
    (ref_from_ext_out ? 12'h0_05 : 12'h8_C9)) else $error("usb retune");
  probe_pulse_a: assert property (probe_valid_out |=> !probe_valid_out)
    else $error("probe request longer than one cycle");
  miss_next_a: assert property (probe_done_in && !hit
    && probe_req_out.src inside {SRC_NOR, SRC_NAND, SRC_SPI, SRC_I2C, SRC_USB}
    |-> !probe_valid_out ##1 probe_valid_out)
    else $error("next probe not one cycle after miss");
  load_order_a: assert property ($rose(load_valid_out)
    |-> (load_req_out.kind == LOAD_CFG) == hit_cfg)
    else $error("wrong first load kind");
  settle_wait_a: assert property (jump_out
    |-> settle >= 32'(200 * MS_CYCLES)) else $error("jump before settle");
  jump_entry_a: assert property (jump_out |-> entry_out == hit_entry)
    else $error("wrong entry address");
  handover_a: assert property (jump_out |-> gates == '0
    && idle_config_out == 16'hFF_FE) else $error("handover state");
  rtc_off_a: assert property ((!rtc_osc_en_in) [*6]
    |-> !rtc_access_ok_out) else $error("rtc window open");
  nor_hit_c: cover property (hit && probe_req_out.src == SRC_NOR);
  i2c_hit_c: cover property (hit && probe_req_out.src == SRC_I2C);
  usb_probe_c: cover property (probe_valid_out && probe_req_out.src == SRC_USB);
  jump_cfg_c: cover property (jump_out && hit_cfg);
endmodule
bind boot_clock_sequencer boot_seq_monitor #(
  .BOOT_SIGNATURE(BOOT_SIGNATURE), .MS_CYCLES(MS_CYCLES)) u_mon (.*);
`default_nettype wire

// *** bench/boot_media_model.sv ***
// boot_media_model.sv: behavioural stand-in for the boot memories
// assumes one probe outstanding at a time; probes are numbered from reset
`timescale 1ns/1ps
`default_nettype none
module boot_media_model #(
  parameter logic [15:0] SIGNATURE = 16'h0A_5A,
  parameter logic [23:0] ENTRY     = 24'h01_2340
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       probe_valid_in,
  input  wire logic       load_valid_in,
  input  wire logic [7:0] hit_at_in,
  input  wire logic       slow_in,
  input  wire logic       cfg_in,
  output logic            probe_done_out,
  output logic [15:0]     probe_data_out,
  output logic            load_done_out,
  output logic            cfg_present_out,
  output logic [23:0]     entry_addr_out
);
  logic [7:0]  count;
  logic [3:0]  pwait;
  logic [3:0]  lwait;
  logic        busy;
  logic        hit;
  logic [15:0] noise;
  // data churns outside the done cycle so a late sample cannot match
  assign probe_data_out  = probe_done_out ? (hit ? SIGNATURE : ~SIGNATURE)
                                          : noise;
  assign entry_addr_out  = probe_done_out ? ENTRY : {noise, noise[7:0]};
  assign cfg_present_out = cfg_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {count, pwait, lwait, busy, hit, probe_done_out, load_done_out} <= '0;
      noise <= 16'hC3_96;
    end else begin
      noise          <= noise + 16'h1_357;
      probe_done_out <= 1'b0;
      if (probe_valid_in) begin
        busy  <= 1'b1;
        pwait <= slow_in ? 4'h9 : 4'h0;
      end else if (busy && pwait != 4'h0) begin
        pwait <= pwait - 4'h1;
      end else if (busy) begin
        busy           <= 1'b0;
        probe_done_out <= 1'b1;
        hit            <= count == hit_at_in;
        count          <= count + 8'h01;
      end
      // register config is acknowledged only; it never touches pll or timer
      lwait <= (load_valid_in && !load_done_out) ? lwait + 4'h1 : 4'h0;
      load_done_out <= load_valid_in && !load_done_out
                       && lwait == (slow_in ? 4'h7 : 4'h1);
    end
  end
endmodule
`default_nettype wire

// *** bench/test_boot_clock_sequencer.sv ***
// test_boot_clock_sequencer.sv: self-checking bench for the boot sequencer
// assumes the monitor is bound to the design and the media model answers
`timescale 1ns/1ps
`default_nettype none
module test_boot_clock_sequencer;
  import boot_seq_pkg::*;
  // short millisecond keeps the 200 ms settle at 800 cycles
  localparam int unsigned MS    = 4;
  localparam logic [15:0] SIG   = 16'h3C_A5;
  localparam logic [23:0] ENTRY = 24'h01_2340;
  logic        clk_in, rst_n_in, clk_sel_in, rtc_osc_en_in, slow, cfg;
  logic [7:0]  hit_at;
  logic        ref_from_ext_out, rtc_access_ok_out, usb_osc_disable_out;
  logic [15:0] periph_gate_ctrl_a_out, periph_gate_ctrl_b_out, probe_data_in;
  logic        probe_valid_out, probe_done_in, load_valid_out, load_done_in;
  logic        cfg_present_in, jump_out, boot_busy_out;
  logic [23:0] entry_addr_in, entry_out;
  probe_req_t  probe_req_out;
  probe_req_t  plog [64];
  int          n, fail_count, checked;
  bit          seen;
  // ------------
  // design, media and clock
  // ------------
  boot_clock_sequencer #(.BOOT_SIGNATURE(SIG), .MS_CYCLES(MS)) u_dut (
    .clk_in, .rst_n_in, .clk_sel_in, .rtc_osc_en_in, .ref_from_ext_out,
    .rtc_run_out(), .rtc_access_ok_out, .pll_cfg_out(),
    .clock_output_pin_slow_slew_out(), .clock_output_pin_en_out(), .bandgap_trim_out(),
    .idle_config_out(), .periph_gate_ctrl_a_out, .periph_gate_ctrl_b_out,
    .periph_soft_reset_count_out(), .periph_reset_ctrl_out(),
    .usb_osc_disable_out, .usb_osc_bias_disable_out(),
    .memory_map_mode_out(), .fetch_addr_out(), .probe_valid_out,
    .probe_req_out, .probe_done_in, .probe_data_in, .load_valid_out,
    .load_req_out(), .load_done_in, .cfg_present_in, .entry_addr_in,
    .jump_out, .entry_out, .boot_busy_out);
  boot_media_model #(.SIGNATURE(SIG), .ENTRY(ENTRY)) u_media (
    .clk_in, .rst_n_in, .probe_valid_in(probe_valid_out),
    .load_valid_in(load_valid_out), .hit_at_in(hit_at), .slow_in(slow),
    .cfg_in(cfg), .probe_done_out(probe_done_in),
    .probe_data_out(probe_data_in), .load_done_out(load_done_in),
    .cfg_present_out(cfg_present_in), .entry_addr_out(entry_addr_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (!rst_n_in) n = 0;
    else if (probe_valid_out && n < 63) begin
      plog[n] = probe_req_out;
      n++;
    end
  end
  // ------------
  // shared tasks
  // ------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic boot(input logic sel, rtc, sl, cf, input logic [7:0] at);
    @(posedge clk_in);
    #1;
    rst_n_in      = 1'b0;
    clk_sel_in    = sel;
    rtc_osc_en_in = rtc;
    slow          = sl;
    cfg           = cf;
    hit_at        = at;
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
  endtask
  task automatic wait_jump(input int lim);
    seen = 0;
    repeat (lim) begin
      @(posedge clk_in);
      #1;
      if (jump_out === 1'b1) begin
        seen = 1;
        break;
      end
    end
  endtask
  task automatic chk_order(input int cnt);
    boot_src_t s;
    for (int i = 0; i < cnt; i++) begin
      s = i < 2 ? boot_src_t'(i) : i < 6 ? SRC_SPI
        : i < 8 ? boot_src_t'(i - 3) : SRC_USB;
      chk(24'(plog[i].src), 24'(s));
      if (i < 2) chk(24'(plog[i].access16), 24'(i == 0));
      if (s == SRC_SPI) begin
        chk(24'(plog[i].bus_sel), i < 4 ? 24'h00_0005 : 24'h00_0006);
        chk(24'(plog[i].addr24), 24'(i % 2));
        chk(24'(plog[i].rate_khz), 24'h00_01F4);
      end
      if (s == SRC_I2C) begin
        chk(24'(plog[i].i2c_addr), 24'h00_0050);
        chk(24'(plog[i].rate_khz), 24'h00_0190);
      end
    end
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic t_nor_hit;
    boot(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    wait_jump(3000);
    chk(24'(seen), 24'h00_0001);
    chk(entry_out, ENTRY);
    chk(24'(n), 24'h00_0001);
    chk(24'(ref_from_ext_out), 24'h00_0000);
    chk({periph_gate_ctrl_b_out[7:0], periph_gate_ctrl_a_out}, '0);
    @(posedge clk_in);
    #1;
    chk(24'(jump_out), 24'h00_0000);
    chk(24'(boot_busy_out), 24'h00_0000);
  endtask
  task automatic t_i2c_hit;
    boot(1'b1, 1'b0, 1'b1, 1'b0, 8'h06);
    wait_jump(4000);
    chk(24'(seen), 24'h00_0001);
    chk_order(7);
    chk(24'(ref_from_ext_out), 24'h00_0001);
    chk(24'(rtc_access_ok_out), 24'h00_0000);
  endtask
  task automatic t_usb_loop;
    boot(1'b0, 1'b1, 1'b1, 1'b1, 8'hFF);
    wait_jump(900);
    chk(24'(seen), 24'h00_0000);
    chk_order(12);
    chk(24'(usb_osc_disable_out), 24'h00_0000);
    boot(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    wait_jump(3000);
    chk(24'(seen), 24'h00_0001);
    chk(24'(plog[0].src), 24'(SRC_NOR));
  endtask
  task automatic give_verdict;
    $display("TB: checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_n_in, clk_sel_in, slow, cfg, hit_at} = '0;
    rtc_osc_en_in = 1'b1;
    t_nor_hit();
    t_i2c_hit();
    t_usb_loop();
    give_verdict();
  end
  // four boots of at most a few thousand cycles each
  initial begin
    #80_000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// *** hdl/boot_clock_sequencer.sv ***
// boot_clock_sequencer.sv: post-reset clock setup and boot source search
// assumes probe and load engines outside answer with one-cycle done pulses
//
// Behaviour
// [R1] system clock reference is external pin or 32.768 kHz oscillator
// [R2] clock-source select pin stays fixed after reset release
// [R3] disabled real-time oscillator stops rtc and blocks its register window
// [R4] select low: pll 375x, multiplier 749, divide-by-8 on, out divider 0
// [R5] select high: pll bypassed, external pin drives system clock
// [R6] before usb probe retune pll to about 36 MHz (3x or 1125x)
// [R7] all peripheral clocks gated off from hardware reset
// [R8] gate registers and reset registers drive peripheral clocks and resets
// [R9] only probed peripheral clocked; at handover all off, all idle but cpu
// [R10] usb oscillator bits cleared, then up to 10 ms settle wait
// [R11] cpu fetches vector 0xFFFF00 from internal rom, pll bypassed
// [R12] slew, idle, pll, trim, clock output off, in that order
// [R13] nor probe: two bytes, 16-bit access over async chip selects
// [R14] nand probe: two bytes, 8-bit access, then serial memory
// [R15] spi cs0 500 kHz, bus select 5 then 6, 16 then 24-bit address
// [R16] i2c probe target 0x50 at 400 kHz, then mmc
// [R17] with no earlier signature the usb probe repeats until reset
// [R18] valid image: optional register config, then copy sections
// [R19] start timer zero for 200 ms; run nothing before it ends
// [R20] after settling jump to the image entry address
// [R21] image register config leaves pll output and timer zero alone
// [R22] sequence starts by itself after every reset
// [R23] expected boot signature is a design parameter
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_cfg.svh"
module boot_clock_sequencer
  import boot_seq_pkg::*;
#(
  parameter logic [15:0] BOOT_SIGNATURE = `DEFAULT_SIGNATURE,
  parameter int unsigned MS_CYCLES      = `MS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_sel_in,
  input  wire logic        rtc_osc_en_in,
  output logic             ref_from_ext_out,
  output logic             rtc_run_out,
  output logic             rtc_access_ok_out,
  output pll_cfg_t         pll_cfg_out,
  output logic             clock_output_pin_slow_slew_out,
  output logic             clock_output_pin_en_out,
  output logic             bandgap_trim_out,
  output logic [15:0]      idle_config_out,
  output logic [15:0]      periph_gate_ctrl_a_out,
  output logic [15:0]      periph_gate_ctrl_b_out,
  output logic [15:0]      periph_soft_reset_count_out,
  output logic [15:0]      periph_reset_ctrl_out,
  output logic             usb_osc_disable_out,
  output logic             usb_osc_bias_disable_out,
  output logic             memory_map_mode_out,
  output logic [23:0]      fetch_addr_out,
  output logic             probe_valid_out,
  output probe_req_t       probe_req_out,
  input  wire logic        probe_done_in,
  input  wire logic [15:0] probe_data_in,
  output logic             load_valid_out,
  output load_req_t        load_req_out,
  input  wire logic        load_done_in,
  input  wire logic        cfg_present_in,
  input  wire logic [23:0] entry_addr_in,
  output logic             jump_out,
  output logic [23:0]      entry_out,
  output logic             boot_busy_out
);

  // ------------
  // pins and state
  // ------------
  typedef enum logic [3:0] {
    ST_FETCH, ST_SLEW, ST_IDLE, ST_PLL, ST_TRIM, ST_CLKOFF,
    ST_PROBE, ST_PROBE_WAIT, ST_USB_PLL, ST_USB_OSC, ST_CFG,
    ST_COPY, ST_SETTLE_START, ST_SETTLE, ST_JUMP, ST_DONE
  } state_t;

  state_t      state;
  state_t      next_state;
  boot_src_t   src;
  logic [1:0]  spi_try;
  logic [1:0]  pins;
  logic        clk_sel;
  logic        rtc_on;
  logic [31:0] gate;
  logic        timer_start;
  logic [7:0]  timer_ms;
  logic        timer_done;
  logic [4:0]  gate_pos;
  boot_src_t   next_src;
  logic [1:0]  next_try;

  // select pin is strapped; sampled continuously but assumed static
  pin_sync3 #(.W(2)) u_pins (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    ({rtc_osc_en_in, clk_sel_in}),
    .level_out (pins)
  );
  assign clk_sel = pins[0]; // R2
  assign rtc_on  = pins[1];

  settle_timer_zero #(.TICK_CYCLES(MS_CYCLES)) u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (timer_start),
    .ms_count_in (timer_ms),
    .done_out    (timer_done)
  );

  // ------------
  // decode
  // ------------
  wire sig_ok       = (probe_data_in == BOOT_SIGNATURE); // R23
  wire probe_hit    = probe_done_in && sig_ok;
  wire probe_miss   = probe_done_in && !sig_ok;
  wire spi_last     = (spi_try == 2'h3);

  assign gate_pos = (next_src == SRC_SPI) ? `GATE_SPI :
                    (next_src == SRC_I2C) ? `GATE_I2C :
                    (next_src == SRC_MMC) ? `GATE_MMC :
                    (next_src == SRC_USB) ? `GATE_USB : `GATE_EMIF;

  assign ref_from_ext_out  = clk_sel; // R1
  assign rtc_run_out       = rtc_on; // R3
  assign rtc_access_ok_out = rtc_on; // R3
  assign probe_valid_out   = (state == ST_PROBE);
  assign load_valid_out    = (state == ST_CFG) || (state == ST_COPY);
  assign timer_start       = (state == ST_SETTLE_START) ||
                             (state == ST_USB_PLL);
  assign timer_ms          = (state == ST_USB_PLL) ? `USB_OSC_TIME_MS
                                                   : `SETTLE_TIME_MS;
  assign boot_busy_out     = (state != ST_DONE);
  assign periph_gate_ctrl_a_out = gate[15:0];
  assign periph_gate_ctrl_b_out = gate[31:16];

  // ------------
  // next state
  // ------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_FETCH:  next_state = ST_SLEW; // R22
      ST_SLEW:   next_state = ST_IDLE; // R12
      ST_IDLE:   next_state = ST_PLL;
      ST_PLL:    next_state = ST_TRIM;
      ST_TRIM:   next_state = ST_CLKOFF;
      ST_CLKOFF: next_state = ST_PROBE;
      ST_PROBE:  next_state = ST_PROBE_WAIT;
      ST_PROBE_WAIT: begin
        if (probe_hit) begin
          next_state = cfg_present_in ? ST_CFG : ST_COPY; // R18
        end else if (probe_miss) begin
          if (src == SRC_MMC) begin
            next_state = ST_USB_PLL;
          end else begin
            next_state = ST_PROBE; // R17
          end
        end
      end
      ST_USB_PLL: next_state = ST_USB_OSC;
      ST_USB_OSC: next_state = timer_done ? ST_PROBE : ST_USB_OSC; // R10
      ST_CFG:     next_state = load_done_in ? ST_COPY : ST_CFG;
      ST_COPY:    next_state = load_done_in ? ST_SETTLE_START : ST_COPY;
      ST_SETTLE_START: next_state = ST_SETTLE; // R19
      ST_SETTLE:  next_state = timer_done ? ST_JUMP : ST_SETTLE; // R19
      ST_JUMP:    next_state = ST_DONE;
      ST_DONE:    next_state = ST_DONE;
    endcase
  end

  // ------------
  // sequence, source walk and clock setup
  // ------------
  // next source is combinational so the request is ready with its strobe
  always_comb begin
    next_src = src;
    next_try = spi_try;
    if (probe_miss) begin
      unique case (src)
        SRC_NOR:  next_src = SRC_NAND; // R13
        SRC_NAND: next_src = SRC_SPI; // R14
        SRC_SPI: begin
          next_try = spi_try + 2'h1; // R15
          if (spi_last) begin
            next_src = SRC_I2C;
          end
        end
        SRC_I2C:  next_src = SRC_MMC; // R16
        SRC_MMC:  next_src = SRC_USB;
        SRC_USB:  next_src = SRC_USB; // R17
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state   <= ST_FETCH;
      src     <= SRC_NOR;
      spi_try <= 2'h0;
    end else begin
      state   <= next_state;
      src     <= next_src;
      spi_try <= next_try;
    end
  end

  // pll: bypassed from reset, the first edge sees the vector fetch
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pll_cfg_out <= '{powered: 1'b0, bypass: 1'b1, mult: 12'h0_00,
                       secondary: 2'h0, in_div_en: 1'b0, div8_en: 1'b0,
                       out_div_en: 1'b0, out_div: 7'h00}; // R11
    end else if (state == ST_PLL && !clk_sel) begin
      pll_cfg_out <= '{powered: 1'b1, bypass: 1'b0, mult: `PLL_MULT_RTC,
                       secondary: `PLL_SECONDARY, in_div_en: 1'b0,
                       div8_en: 1'b1, out_div_en: 1'b1,
                       out_div: `PLL_OUT_DIV}; // R4
    end else if (state == ST_PLL) begin
      pll_cfg_out.bypass <= 1'b1; // R5
    end else if (state == ST_USB_PLL) begin
      pll_cfg_out.powered <= 1'b1; // R6
      pll_cfg_out.bypass  <= 1'b0;
      pll_cfg_out.mult    <= clk_sel ? `PLL_MULT_USB_EXT
                                     : `PLL_MULT_USB_RTC; // R6
    end
  end

  // pad, trim, idle and memory map controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_output_pin_slow_slew_out    <= 1'b0;
      clock_output_pin_en_out <= 1'b1;
      bandgap_trim_out        <= 1'b0;
      idle_config_out         <= 16'h0000;
      memory_map_mode_out     <= 1'b0; // R11
      fetch_addr_out          <= `RESET_VECTOR; // R11
      usb_osc_disable_out      <= 1'b1;
      usb_osc_bias_disable_out <= 1'b1;
    end else begin
      if (state == ST_SLEW) begin
        clock_output_pin_slow_slew_out <= 1'b1; // R12
      end
      if (state == ST_IDLE) begin
        idle_config_out <= `IDLE_ALL; // R9
      end
      if (state == ST_TRIM) begin
        bandgap_trim_out <= 1'b1; // R12
      end
      if (state == ST_CLKOFF) begin
        clock_output_pin_en_out <= 1'b0; // R12
      end
      if (state == ST_USB_PLL) begin
        usb_osc_disable_out      <= 1'b0; // R10
        usb_osc_bias_disable_out <= 1'b0; // R10
      end
    end
  end

  // ------------
  // peripheral clocks and resets
  // ------------
  // only one gate bit at a time: a stray clock costs power at boot
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gate                        <= 32'h0000_0000; // R7
      periph_reset_ctrl_out       <= 16'h0000;
      periph_soft_reset_count_out <= 16'h0000;
    end else begin
      gate <= (next_state == ST_PROBE || next_state == ST_PROBE_WAIT ||
               next_state == ST_CFG || next_state == ST_COPY)
              ? (32'h0000_0001 << gate_pos) : 32'h0000_0000; // R9
      periph_soft_reset_count_out <= `SOFT_RESET_COUNT; // R8
      periph_reset_ctrl_out <= (state == ST_PROBE)
                               ? gate[15:0] | gate[31:16] : 16'h0000; // R8
    end
  end

  // ------------
  // requests and handover
  // ------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      probe_req_out <= '{src: SRC_NOR, access16: 1'b1, addr24: 1'b0,
                         bus_sel: 3'h0, i2c_addr: 7'h00,
                         rate_khz: 10'h000};
      load_req_out  <= '{src: SRC_NOR, kind: LOAD_CFG};
      jump_out      <= 1'b0;
      entry_out     <= 24'h00_0000;
    end else begin
      probe_req_out.src      <= next_src;
      probe_req_out.access16 <= (next_src != SRC_NAND); // R13 R14
      probe_req_out.addr24   <= (next_src == SRC_SPI) && next_try[0]; // R15
      probe_req_out.bus_sel  <= (next_src != SRC_SPI) ? 3'h0 :
                                next_try[1] ? `BUS_SEL_SECOND
                                            : `BUS_SEL_FIRST; // R15
      probe_req_out.i2c_addr <= (next_src == SRC_I2C) ? `I2C_TARGET
                                                      : 7'h00; // R16
      probe_req_out.rate_khz <= (next_src == SRC_SPI) ? `SPI_RATE_KHZ :
                                (next_src == SRC_I2C) ? `I2C_RATE_KHZ
                                                      : 10'h000;
      load_req_out.src  <= src;
      load_req_out.kind <= (next_state == ST_COPY) ? LOAD_COPY
                                                   : LOAD_CFG; // R18
      if (probe_hit) begin
        entry_out <= entry_addr_in;
      end
      jump_out <= (state == ST_JUMP); // R20
    end
  end

endmodule
`default_nettype wire

// *** hdl/boot_seq_cfg.svh ***
// boot_seq_cfg.svh: constants of the boot clock sequencer
// assumes a 200 MHz system clock; included by bare name
`ifndef BOOT_SEQ_CFG_SVH
`define BOOT_SEQ_CFG_SVH

// ------------
// timing
// ------------
`define CLK_PERIOD_PS     5000
`define PS_PER_MS         1000000000
`define MS_CYCLES         (`PS_PER_MS / `CLK_PERIOD_PS)
`define SETTLE_TIME_MS    8'h00_C8
`define USB_OSC_TIME_MS   8'h00_0A

// ------------
// pll settings
// ------------
`define PLL_MULT_RTC      12'h2_ED
`define PLL_MULT_USB_RTC  12'h8_C9
`define PLL_MULT_USB_EXT  12'h0_05
`define PLL_SECONDARY     2'h0
`define PLL_OUT_DIV       7'h00

// ------------
// probe parameters and reset values
// ------------
`define SPI_RATE_KHZ      10'h1_F4
`define I2C_RATE_KHZ      10'h1_90
`define I2C_TARGET        7'h50
`define BUS_SEL_FIRST     3'h5
`define BUS_SEL_SECOND    3'h6
`define RESET_VECTOR      24'hFF_FF00
`define IDLE_ALL          16'hFF_FE
`define SOFT_RESET_COUNT  16'h00_08
`define DEFAULT_SIGNATURE 16'h0A_5A

// ------------
// peripheral clock gate bit positions in {ctrl_b, ctrl_a}
// ------------
`define GATE_EMIF         5'h01
`define GATE_SPI          5'h05
`define GATE_I2C          5'h06
`define GATE_MMC          5'h0B
`define GATE_USB          5'h12

`endif

// *** hdl/boot_seq_pkg.sv ***
// boot_seq_pkg.sv: types shared by the boot clock sequencer files
// assumes nothing beyond a SystemVerilog compiler
package boot_seq_pkg;

  typedef enum logic [2:0] {
    SRC_NOR, SRC_NAND, SRC_SPI, SRC_I2C, SRC_MMC, SRC_USB
  } boot_src_t;

  typedef enum logic {LOAD_CFG, LOAD_COPY} load_kind_t;

  typedef struct packed {
    logic        powered;
    logic        bypass;
    logic [11:0] mult;
    logic [1:0]  secondary;
    logic        in_div_en;
    logic        div8_en;
    logic        out_div_en;
    logic [6:0]  out_div;
  } pll_cfg_t;

  typedef struct packed {
    boot_src_t   src;
    logic        access16;
    logic        addr24;
    logic [2:0]  bus_sel;
    logic [6:0]  i2c_addr;
    logic [9:0]  rate_khz;
  } probe_req_t;

  typedef struct packed {
    boot_src_t   src;
    load_kind_t  kind;
  } load_req_t;

endpackage

// *** hdl/pin_sync3.sv ***
// pin_sync3.sv: three-stage synchroniser for static pins
// assumes pins change rarely; output follows once stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // stages run through reset so the strap is settled at release
  always_ff @(posedge clk_in) begin
    stage1 <= pin_in;
    stage2 <= stage1;
    stage3 <= stage2;
    if (!rst_n_in) begin
      level_out <= stage3;
    end else begin
      // glitch filter: a bit moves only once stages 2 and 3 agree
      level_out <= (stage2 & stage3) | (level_out & (stage2 | stage3));
    end
  end
endmodule
`default_nettype wire

// *** hdl/settle_timer_zero.sv ***
// settle_timer_zero.sv: millisecond timer with an 18-bit tick divider
// assumes start_in is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`default_nettype none
module settle_timer_zero #(
  parameter int unsigned TICK_CYCLES = 200000
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic [7:0] ms_count_in,
  output logic            done_out
);
  logic [17:0] div;
  logic [7:0]  ms_left;
  logic        busy;
  wire         ms_tick = busy && (div == 18'(TICK_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div      <= '0;
      ms_left  <= '0;
      busy     <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in) begin
      div      <= '0;
      ms_left  <= ms_count_in;
      busy     <= 1'b1;
      done_out <= 1'b0;
    end else if (busy) begin
      div <= ms_tick ? 18'h0_0000 : div + 18'h0_0001;
      if (ms_tick) begin
        ms_left <= ms_left - 8'h01;
        if (ms_left == 8'h01) begin
          busy     <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire
